// ### hdl/sdram_lp_core.sv
// two-bank sdram core: clock gating, power-down, self-refresh and data masking
module sdram_lp_core
   import sdram_lp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire cmd_pins_t cmd_pins,
   input wire logic bank_sel,
   input wire logic auto_close,
   input wire logic [COL_W-1:0] col_addr,
   input wire mode_t mode_bits,
   input wire logic clock_gate_pin,
   input wire logic data_mask_pin,
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe,
   output logic [1:0] bank_open,
   output logic suspended,
   output logic power_down,
   output logic self_refresh,
   output logic write_stall
);
   pins_t meta_q;
   pins_t s;
   logic cke_prev_q;
   lp_state_t state_q;
   burst_kind_t kind_q;
   mode_t mode_q;
   logic [1:0] bank_open_q;
   logic [3:0] beat_q;
   logic [1:0] lat_q;
   logic bbank_q;
   logic bclose_q;
   logic [COL_W-1:0] bcol_q;
   logic mask_d1_q;
   logic [DATA_W-1:0] dq_o_q;
   logic dq_oe_q;
   logic write_stall_q;
   logic ac_done_q;
   logic [DATA_W-1:0] mem_q [2*(2**COL_W)];
   logic [3:0] cmd;
   logic active;
   logic cmd_rd;
   logic cmd_wr;
   logic cmd_nop;
   logic go_pd;
   logic go_self;
   logic [3:0] blen;
   logic [3:0] idx;
   logic [COL_W-1:0] beat_col;
   logic wr_beat;
   logic push;
   logic rd_emit;
   logic beat_done;
   logic burst_end;
   logic ac_pending;
   wr_word_t fifo_in;
   wr_word_t fifo_out;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;

   // two-flop synchroniser for every pin except clk and rst_n
   always_ff @(posedge clk)
   begin
      meta_q <= {cmd_pins, bank_sel, auto_close, col_addr, mode_bits, clock_gate_pin,
                 data_mask_pin, dq_i};
      s <= meta_q;
   end

   assign cmd = s.cmd.cs_n ? CMD_NOP : {1'b0, s.cmd.ras_n, s.cmd.cas_n, s.cmd.we_n};
   assign cmd_nop = (cmd == CMD_NOP);
   // the edge after a low gate is ignored
   assign active = (state_q == st_run) && cke_prev_q;
   assign cmd_rd = active && (cmd == CMD_READ) && bank_open_q[s.bank];
   assign cmd_wr = active && (cmd == CMD_WRITE) && bank_open_q[s.bank];
   assign ac_pending = (kind_q == burst_write) && bclose_q;
   assign go_self = active && !s.clock_gate && (cmd == CMD_REF) && (bank_open_q == 2'h0)
                    && (kind_q == burst_none);
   assign go_pd = active && !s.clock_gate && cmd_nop && (kind_q == burst_none);

   // burst length and beat address order
   always_comb
   begin
      blen = 4'h1 << mode_q.blen_code;
      idx = cmd_wr ? 4'h0 : beat_q;
      if (mode_q.interleaved)
         beat_col = (cmd_wr ? s.col : bcol_q) ^ idx[COL_W-1:0];
      else
         beat_col = ((cmd_wr ? s.col : bcol_q) & ~(blen - 4'h1))
                    | (((cmd_wr ? s.col : bcol_q) + idx) & (blen - 4'h1));
   end

   assign wr_beat = (cmd_wr || (active && kind_q == burst_write && !cmd_rd));
   assign push = wr_beat && !s.data_mask;
   assign beat_done = wr_beat ? !(push && !fifo_in_ready) : rd_emit;
   assign rd_emit = active && (kind_q == burst_read) && (lat_q <= LAT_MIN) && !cmd_wr;
   assign burst_end = beat_done && (idx == blen - 4'h1);
   assign fifo_in = '{bank: (cmd_wr ? s.bank : bbank_q), col: beat_col, data: s.dq};
   assign fifo_out_ready = !rd_emit;

   word_fifo #(
      .WIDTH($bits(wr_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   // gate history and power state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cke_prev_q <= 1'b1;
         state_q <= st_run;
      end
      else
      begin
         cke_prev_q <= s.clock_gate;
         case (state_q)
            st_run:
            begin
               if (go_self)
                  state_q <= st_self_refresh;
               else if (go_pd)
                  state_q <= st_power_down;
               else if (!s.clock_gate && kind_q != burst_none)
                  state_q <= st_suspend;
            end
            st_suspend:
               if (s.clock_gate)
                  state_q <= st_run;
            st_power_down:
               if (s.clock_gate)
                  state_q <= st_run;
            st_self_refresh:
               if (s.clock_gate)
                  state_q <= st_run;
            default:
               state_q <= st_run;
         endcase
      end
   end

   // mode register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         mode_q <= MODE_RESET;
      else if (active && cmd == CMD_MRS)
         mode_q <= s.mode_bits;
   end

   // bank open tracking
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         bank_open_q <= 2'h0;
      else if (go_pd && ac_pending)
         bank_open_q[bbank_q] <= 1'b0;
      else if (active)
      begin
         if (cmd == CMD_ACT)
            bank_open_q[s.bank] <= 1'b1;
         else if (cmd == CMD_PRE && s.auto_close)
            bank_open_q <= 2'h0;
         else if (cmd == CMD_PRE)
            bank_open_q[s.bank] <= 1'b0;
         else if (burst_end && (cmd_wr ? s.auto_close : bclose_q))
            bank_open_q[cmd_wr ? s.bank : bbank_q] <= 1'b0;
      end
   end

   // burst engine
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         kind_q <= burst_none;
         beat_q <= BEAT_RESET;
         lat_q <= LAT_RESET;
         bbank_q <= 1'b0;
         bclose_q <= 1'b0;
         bcol_q <= '0;
      end
      else if (go_pd && ac_pending)
         kind_q <= burst_none;
      else if (active)
      begin
         if (cmd_rd)
         begin
            kind_q <= burst_read;
            beat_q <= BEAT_RESET;
            lat_q <= (mode_q.read_latency < LAT_MIN) ? LAT_MIN : mode_q.read_latency;
            bbank_q <= s.bank;
            bclose_q <= s.auto_close;
            bcol_q <= s.col;
         end
         else if (cmd_wr)
         begin
            kind_q <= burst_end ? burst_none : burst_write;
            beat_q <= beat_done ? 4'h1 : BEAT_RESET;
            bbank_q <= s.bank;
            bclose_q <= s.auto_close;
            bcol_q <= s.col;
         end
         else if (cmd == CMD_PRE && (s.auto_close || s.bank == bbank_q))
            kind_q <= burst_none;
         else if (kind_q != burst_none)
         begin
            if (lat_q > LAT_MIN)
               lat_q <= lat_q - 2'h1;
            if (burst_end)
               kind_q <= burst_none;
            else if (beat_done)
               beat_q <= beat_q + 4'h1;
         end
      end
   end

   // read mask delay line and output drive
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mask_d1_q <= 1'b0;
         dq_o_q <= '0;
         dq_oe_q <= 1'b0;
      end
      else if (active)
      begin
         mask_d1_q <= s.data_mask;
         if (rd_emit)
         begin
            dq_o_q <= mem_q[{bbank_q, beat_col}];
            dq_oe_q <= !mask_d1_q;
         end
         else
            dq_oe_q <= 1'b0;
      end
      else if (state_q != st_run)
         dq_oe_q <= dq_oe_q && (state_q == st_suspend);
   end

   // array write from the fifo
   always_ff @(posedge clk)
   begin
      if (fifo_out_valid && fifo_out_ready)
         mem_q[{fifo_out.bank, fifo_out.col}] <= fifo_out.data;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         write_stall_q <= 1'b0;
      else
         write_stall_q <= push && !fifo_in_ready;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ac_done_q <= 1'b0;
      else if (active && wr_beat && burst_end && !(cmd == CMD_ACT || cmd == CMD_PRE)
               && (cmd_wr ? s.auto_close : bclose_q))
         ac_done_q <= 1'b1;
      else if (active && (cmd_rd || cmd_wr || cmd == CMD_ACT))
         ac_done_q <= 1'b0;
   end

   assign dq_o = dq_o_q;
   assign dq_oe = dq_oe_q;
   assign bank_open = bank_open_q;
   assign suspended = (state_q == st_suspend);
   assign power_down = (state_q == st_power_down);
   assign self_refresh = (state_q == st_self_refresh);
   assign write_stall = write_stall_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   pd_entry_a: assert property (go_pd && !go_self |=> power_down)
      else $error("power-down not entered one cycle after entry command");
   pd_close_a: assert property (go_pd && ac_done_q |-> !bank_open_q[bbank_q])
      else $error("auto-closing write bank still open at power-down");
   self_hold_a: assert property (self_refresh && !s.clock_gate |=> self_refresh)
      else $error("self-refresh left while gate low");
   self_ignore_a: assert property (self_refresh |=> $stable(mode_q) && $stable(bank_open_q))
      else $error("state changed during self-refresh");
   wr_mask_a: assert property (wr_beat && s.data_mask |-> !push)
      else $error("masked write beat entered the write path");
   rd_mask_a: assert property (rd_emit && $past(s.data_mask, 1) |=> !dq_oe)
      else $error("masked read beat was driven");
   susp_freeze_a: assert property (state_q == st_run && !cke_prev_q |=> $stable(beat_q))
      else $error("burst advanced while suspended");
   autoclose_a: assert property (active && burst_end && !cmd_wr && bclose_q && cmd_nop
      |=> !bank_open_q[$past(bbank_q)])
      else $error("auto-closing access left its bank open");
   close_one_a: assert property (active && cmd == CMD_PRE && !s.auto_close
      |=> bank_open_q[!$past(s.bank)] == $past(bank_open_q[!s.bank]))
      else $error("close of one bank disturbed the other");
   mrs_load_a: assert property (active && cmd == CMD_MRS |=> mode_q == $past(s.mode_bits))
      else $error("mode register not loaded");
   nop_keep_a: assert property (active && cmd_nop && kind_q == burst_none
      && s.clock_gate |=> $stable(bank_open_q) && kind_q == burst_none)
      else $error("idle command changed state");
endmodule

// ### hdl/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
module word_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
   assign out_valid = wr_ptr_q != rd_ptr_q;
   assign out_data = mem_q[rd_ptr_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_ptr_q[AW-1:0]] <= in_data;
   end
endmodule

// ### shared/sdram_lp_pkg.sv
// shared constants and types for the low-power and data-mask sdram block
package sdram_lp_pkg;
   localparam int DATA_W = 16;
   localparam int COL_W = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int READ_MASK_LAT = 2;
   localparam int SUSPEND_LAT = 1;
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [1:0] LAT_MIN = 2'h1;
   localparam logic [3:0] BEAT_RESET = 4'h0;
   localparam logic [1:0] LAT_RESET = 2'h0;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;
   typedef struct packed {
      logic interleaved;
      logic [1:0] read_latency;
      logic [1:0] blen_code;
   } mode_t;
   localparam mode_t MODE_RESET = mode_t'(5'h0a);
   typedef struct packed {
      cmd_pins_t cmd;
      logic bank;
      logic auto_close;
      logic [COL_W-1:0] col;
      mode_t mode_bits;
      logic clock_gate;
      logic data_mask;
      logic [DATA_W-1:0] dq;
   } pins_t;
   typedef struct packed {
      logic bank;
      logic [COL_W-1:0] col;
      logic [DATA_W-1:0] data;
   } wr_word_t;
   typedef enum {st_run, st_suspend, st_power_down, st_self_refresh} lp_state_t;
   typedef enum {burst_none, burst_read, burst_write} burst_kind_t;
endpackage

// ### tb/ctrl_model.sv
// behavioural memory controller that drives the sdram pins one cycle per step call
module ctrl_model
   import sdram_lp_pkg::*;
#(
   parameter int BURST_REFS = 4096,
   parameter int ROW_CYCLE = 7,
   parameter int WR_IDLE = 4
)
(
   input wire logic clk,
   output cmd_pins_t cmd_pins,
   output logic bank_sel,
   output logic auto_close,
   output logic [COL_W-1:0] col_addr,
   output mode_t mode_bits,
   output logic clock_gate_pin,
   output logic data_mask_pin,
   output logic [DATA_W-1:0] dq_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cmd_pins = cmd_pins_t'(CMD_NOP);
      {bank_sel, auto_close, col_addr, data_mask_pin, dq_i} = '0;
      mode_bits = MODE_RESET;
      clock_gate_pin = 1'b1;
   end
   task automatic step(input logic [3:0] c, input logic b, input logic a,
      input logic [COL_W-1:0] col, input logic m, input logic [DATA_W-1:0] d, input logic g);
      @(posedge clk);
      cmd_pins <= cmd_pins_t'(c);
      bank_sel <= b;
      auto_close <= a;
      col_addr <= col;
      data_mask_pin <= m;
      dq_i <= d;
      clock_gate_pin <= g;
   endtask
   // idle data lines carry a changing pattern, drawn from $urandom each cycle
   task automatic idle(input int n, input logic g);
      repeat (n) step(CMD_NOP, 1'b0, 1'b0, '0, 1'b0, DATA_W'($urandom), g);
   endtask
   task automatic mrs(input mode_t m);
      step(CMD_MRS, 1'b0, 1'b0, '0, 1'b0, DATA_W'($urandom), 1'b1);
      mode_bits <= m;
   endtask
   task automatic pd_enter();
      idle(1, 1'b1);
      idle(1, 1'b0);
   endtask
   // caller has closed both banks before this
   task automatic sr_enter();
      idle(WR_IDLE, 1'b1);
      step(CMD_REF, 1'b0, 1'b0, '0, 1'b0, DATA_W'($urandom), 1'b0);
   endtask
   task automatic sr_exit();
      idle(1, 1'b1);
      idle(ROW_CYCLE, 1'b1);
      repeat (BURST_REFS) step(CMD_REF, 1'b0, 1'b0, '0, 1'b0, DATA_W'($urandom), 1'b1);
   endtask
endmodule

// ### tb/sdram_lowpower_and_data_mask_test.sv
// self-checking bench for the sdram low-power and data-mask core
module sdram_lowpower_and_data_mask_test
   import sdram_lp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   cmd_pins_t cmd_pins;
   mode_t mode_bits, md;
   logic bank_sel, auto_close, clock_gate_pin, data_mask_pin, dq_oe, suspended;
   logic power_down, self_refresh, write_stall;
   logic [COL_W-1:0] col_addr;
   logic [DATA_W-1:0] dq_i, dq_o;
   logic [1:0] bank_open;
   logic [DATA_W-1:0] mem [2][16];
   logic [7:0] cnt, sus;
   int n_fail = 0;
   int tests_run = 0;
   int base = 3; // two synchroniser cycles and the command edge
   always #5 clk = ~clk;
   ctrl_model #(.BURST_REFS(8)) ctrl (.clk(clk), .cmd_pins(cmd_pins), .bank_sel(bank_sel),
      .auto_close(auto_close), .col_addr(col_addr), .mode_bits(mode_bits),
      .clock_gate_pin(clock_gate_pin), .data_mask_pin(data_mask_pin), .dq_i(dq_i));
   sdram_lp_core u_sdram_lp_core (.clk(clk), .rst_n(rst_n), .cmd_pins(cmd_pins),
      .bank_sel(bank_sel), .auto_close(auto_close), .col_addr(col_addr), .mode_bits(mode_bits),
      .clock_gate_pin(clock_gate_pin), .data_mask_pin(data_mask_pin), .dq_i(dq_i), .dq_o(dq_o),
      .dq_oe(dq_oe), .bank_open(bank_open), .suspended(suspended), .power_down(power_down),
      .self_refresh(self_refresh), .write_stall(write_stall));
   task automatic wrap_up();
      $display("tests_run %0d n_fail %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [DATA_W-1:0] exp,
      input logic [DATA_W-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [COL_W-1:0] beat_col(input int s, input int i, input int bl,
      input bit il);
      return il ? COL_W'(s ^ i) : COL_W'((s & ~(bl - 1)) | ((s + i) & (bl - 1)));
   endfunction
   task automatic op(input logic [3:0] c, input logic b, input logic a);
      ctrl.step(c, b, a, '0, 1'b0, DATA_W'($urandom), 1'b1);
      ctrl.idle(5, 1'b1);
      #1;
   endtask
   task automatic wr(input bit b, input int s, input int bl, input bit ac, input bit [15:0] m);
      logic [DATA_W-1:0] d;
      for (int k = 0; k < bl; k++)
      begin
         d = DATA_W'($urandom);
         ctrl.step(k == 0 ? CMD_WRITE : CMD_NOP, b, ac, COL_W'(s), m[k], d, 1'b1);
         if (!m[k])
            mem[b][beat_col(s, k, bl, 1'b0)] = d;
      end
   endtask
   task automatic rd(input bit b, input int s, input int bl, input bit il, input int lat,
      input bit [15:0] m);
      int t;
      t = 0;
      ctrl.step(CMD_READ, b, 1'b0, COL_W'(s), 1'b0, DATA_W'($urandom), 1'b1);
      fork
         for (int k = 1; k < bl + 2; k++)
            ctrl.step(CMD_NOP, b, 1'b0, '0, k + 1 >= lat ? m[k + 1 - lat] : 1'b0,
               DATA_W'($urandom), 1'b1);
         begin
            while (dq_oe !== 1'b1 && t < 20)
            begin
               @(posedge clk);
               #1;
               t++;
            end
            if (t == 20)
               check("read start", 16'h1, 16'h0);
            if (t == 20)
               wrap_up();
            check("read latency", DATA_W'(base + lat), DATA_W'(t));
            for (int k = 0; k <= bl; k++)
            begin
               check("read enable", DATA_W'(!m[k] && k < bl), DATA_W'(dq_oe));
               if (!m[k] && k < bl)
                  check("read data", mem[b][beat_col(s, k, bl, il)], dq_o);
               @(posedge clk);
               #1;
            end
         end
      join
   endtask
   initial
   begin
      #100000;
      n_fail++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(83));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check("reset", '0, DATA_W'({dq_oe, bank_open, suspended, power_down, self_refresh}));
      op(CMD_ACT, 1'b0, 1'b0);
      check("bank open", 16'h1, DATA_W'(bank_open));
      for (int c = 0; c < 16; c += 4)
         wr(1'b0, c, 4, 1'b0, 16'h0);
      wr(1'b0, 6, 4, 1'b0, 16'($urandom));
      ctrl.idle(10, 1'b1);
      check("write stall", 16'h0, DATA_W'(write_stall));
      rd(1'b0, 5, 4, 1'b0, 2, 16'($urandom) & 16'hfffe);
      for (int c = 0; c < 4; c++)
      begin
         md = mode_t'($urandom);
         md.blen_code = 2'(c);
         ctrl.mrs(md);
         ctrl.idle(3, 1'b1);
         rd(1'b0, $urandom % 16, 1 << c, md.interleaved, md.read_latency == 0 ? 1 :
            md.read_latency, 16'($urandom) & 16'hfffe);
      end
      $display("test masking done");
      ctrl.mrs(mode_t'(5'h0a));
      ctrl.idle(3, 1'b1);
      ctrl.step(CMD_READ, 1'b0, 1'b0, '0, 1'b0, '0, 1'b1);
      cnt = '0;
      sus = '0;
      fork
         for (int k = 1; k < 8; k++)
            ctrl.step(4'h8, 1'b0, 1'b0, '0, 1'b0, DATA_W'(k), !(k == 3 || k == 4));
         repeat (16)
         begin
            @(posedge clk);
            #1;
            cnt += 8'(dq_oe);
            sus += 8'(suspended);
         end
      join
      check("suspended beats", 16'd6, DATA_W'(cnt));
      check("suspend span", 16'd2, DATA_W'(sus));
      $display("test suspend done");
      op(CMD_ACT, 1'b1, 1'b0);
      check("both open", 16'h3, DATA_W'(bank_open));
      op(CMD_PRE, 1'b1, 1'b0);
      check("close one", 16'h1, DATA_W'(bank_open));
      op(CMD_ACT, 1'b1, 1'b0);
      op(CMD_PRE, 1'b0, 1'b1);
      check("close all", 16'h0, DATA_W'(bank_open));
      ctrl.mrs(mode_t'(5'h08));
      ctrl.idle(3, 1'b1);
      op(CMD_ACT, 1'b0, 1'b0);
      wr(1'b0, 3, 1, 1'b1, 16'h0);
      ctrl.pd_enter();
      ctrl.step(CMD_ACT, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0);
      ctrl.idle(4, 1'b0);
      #1;
      check("power down", 16'h8, DATA_W'({power_down, self_refresh, bank_open}));
      op(CMD_NOP, 1'b0, 1'b0);
      check("power up", 16'h0, DATA_W'({power_down, self_refresh, bank_open}));
      ctrl.sr_enter();
      ctrl.step(CMD_ACT, 1'b0, 1'b0, '0, 1'b0, '0, 1'b0);
      ctrl.idle(6, 1'b0);
      #1;
      check("self refresh", 16'h4, DATA_W'({power_down, self_refresh, bank_open}));
      ctrl.sr_exit();
      op(CMD_NOP, 1'b0, 1'b0);
      check("refresh exit", 16'h0, DATA_W'({power_down, self_refresh, bank_open}));
      op(CMD_ACT, 1'b0, 1'b0);
      rd(1'b0, 3, 1, 1'b0, 2, 16'h0);
      op(CMD_READ, 1'b0, 1'b1);
      check("read autoclose", 16'h0, DATA_W'(bank_open));
      $display("test low power done");
      wrap_up();
   end
endmodule
